/* File: core/launch_pkg.sv */
// Shared constants and carrier types for the core launch sequencer.
// Assumes one system clock and a shared memory of longs reached through 16-bit byte addresses.
package launch_pkg;
  localparam int NUM_CORES = 8;
  localparam int CORE_ID_W = 3;
  localparam int TARGET_W = 4;
  localparam int COPY_LONGS = 496;
  localparam int LOCAL_ADDR_W = 9;
  localparam int HUB_ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int BOOT_PARAM_W = 16;
  localparam int BOOT_PARAM_LSB = 2;
  localparam int BOOT_PARAM_MSB = 15;
  localparam int LONG_BYTES = 4;
  localparam logic [LOCAL_ADDR_W-1:0] START_PC = 9'h000;
  localparam logic [7:0] RESULT_FAIL = 8'hff;
  localparam int LAUNCH_ACK_CYCLES = 1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PICK = 3'b001,
    ST_COPY = 3'b010,
    ST_DRAIN = 3'b011,
    ST_INIT = 3'b100,
    ST_REPLY = 3'b101
  } seq_state_type;

  typedef struct packed {
    logic targeted;
    logic [TARGET_W-1:0] target;
    logic [HUB_ADDR_W-1:0] routine_address;
    logic [DATA_W-1:0] boot_value;
  } launch_req_type;

  typedef struct packed {
    logic [CORE_ID_W-1:0] core;
    logic [LOCAL_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ram_write_type;
endpackage

/* File: core/word_buffer.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes producer and consumer share the system clock.
`timescale 1ns/1ps
module word_buffer import launch_pkg::*; #(
  parameter int WIDTH = 44,
  parameter int DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_r;
  logic [PW-1:0] rd_r;
  logic [PW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready_out = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out = mem_r[rd_r];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_r] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == PW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == PW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

/* File: core/core_pick.sv */
// Finds the lowest-numbered dormant core.
// Assumes a one-hot-safe activity vector from the sequencer.
`timescale 1ns/1ps
module core_pick import launch_pkg::*; (
  input wire logic [NUM_CORES-1:0] active_in,
  output logic found_out,
  output logic [CORE_ID_W-1:0] id_out
);
  always_comb begin
    found_out = 1'b0;
    id_out = '0;
    for (int i = NUM_CORES - 1; i >= 0; i--) begin
      if (!active_in[i]) begin
        found_out = 1'b1;
        id_out = CORE_ID_W'(i);
      end
    end
  end
endmodule

/* File: core/core_launch_sequencer.sv */
// Launch sequencer that starts processor cores on request of a running core.
// Assumes shared memory answers each read with MEM_RVALID_IN after any delay and cores load local RAM
// writes only on cycles where both their write strobe and RAM_READY_IN are high.
//
// Overview of operation
// R1: Reply with started core ID 0 to 7, or minus one on failure.
// R2: Untargeted request starts the next available core.
// R3: Copy exactly 496 longs from routine address into local RAM.
// R4: Load boot parameter register, clear other special registers before running.
// R5: Started core begins executing at local address 0.
// R6: Only parameter bits 2 through 15 reach the boot parameter register.
// R7: Boot parameter bits 1 and 0 always read zero.
// R8: Running code cannot write its boot parameter register.
// R9: Requester shifts non-address values left by two, limited to 14 bits.
// R10: Requester supplies a private stack region for interpreted code.
// R11: A method-valued target is evaluated by the requester, giving the address.
// R12: Targeted launch restarts that core; target above 7 picks next available.
// R13: Stop request makes the addressed core dormant without clock.
// R14: Failed untargeted launch changes no core state and no local RAM.
`timescale 1ns/1ps
module core_launch_sequencer import launch_pkg::*; (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic REQ_VALID_IN,
  output logic REQ_READY_OUT,
  input wire launch_req_type REQ_IN,
  output logic REPLY_VALID_OUT,
  output logic [7:0] REPLY_ID_OUT,
  input wire logic STOP_VALID_IN,
  input wire logic [CORE_ID_W-1:0] STOP_ID_IN,
  output logic MEM_RD_OUT,
  output logic [HUB_ADDR_W-1:0] MEM_ADDR_OUT,
  input wire logic MEM_RVALID_IN,
  input wire logic [DATA_W-1:0] MEM_RDATA_IN,
  output logic RAM_WE_OUT,
  output ram_write_type RAM_WR_OUT,
  input wire logic RAM_READY_IN,
  output logic [NUM_CORES-1:0] CORE_CLK_EN_OUT,
  output logic [NUM_CORES-1:0] CORE_RESET_OUT,
  output logic [NUM_CORES*BOOT_PARAM_W-1:0] BOOT_PARAM_OUT,
  output logic [LOCAL_ADDR_W-1:0] START_PC_OUT
);
  localparam int RW = $bits(ram_write_type);

  seq_state_type state_r;
  launch_req_type req_r;
  logic [NUM_CORES-1:0] active_r;
  logic [NUM_CORES-1:0] reset_r;
  logic [BOOT_PARAM_W-1:0] boot_r [NUM_CORES];
  logic [CORE_ID_W-1:0] core_r;
  logic [LOCAL_ADDR_W-1:0] issued_r;
  logic [LOCAL_ADDR_W-1:0] written_r;
  logic rd_pend_r;
  logic reply_valid_r;
  logic [7:0] reply_id_r;
  logic free_found;
  logic [CORE_ID_W-1:0] free_id;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [RW-1:0] buf_out;
  logic [RW-1:0] buf_in;
  logic issue;
  logic targeted_ok;

  core_pick u_pick (
    .active_in(active_r),
    .found_out(free_found),
    .id_out(free_id)
  );

  assign buf_in = {core_r, written_r, MEM_RDATA_IN};

  word_buffer #(
    .WIDTH(RW),
    .DEPTH(2)
  ) u_buf (
    .clk_in(MCLK_IN),
    .rst_n_in(RST_N_IN),
    .in_valid_in(MEM_RVALID_IN && rd_pend_r),
    .in_ready_out(buf_in_ready),
    .in_data_in(buf_in),
    .out_valid_out(buf_out_valid),
    .out_ready_in(RAM_READY_IN),
    .out_data_out(buf_out)
  );

  // R11: The address arrives already resolved by the requester.
  assign REQ_READY_OUT = (state_r == ST_IDLE);
  // R12: Targets above 7 fall back to the free search.
  assign targeted_ok = req_r.targeted && (req_r.target < TARGET_W'(NUM_CORES));
  // Reads are issued only while the buffer can take the answer.
  assign issue = (state_r == ST_COPY) && !rd_pend_r && buf_in_ready &&
                 (issued_r != LOCAL_ADDR_W'(COPY_LONGS));
  assign MEM_RD_OUT = issue;
  // R3: Shared memory is walked one long at a time.
  assign MEM_ADDR_OUT = req_r.routine_address +
                        HUB_ADDR_W'({issued_r, 2'b00});
  assign RAM_WE_OUT = buf_out_valid;
  assign RAM_WR_OUT = buf_out;
  assign REPLY_VALID_OUT = reply_valid_r;
  assign REPLY_ID_OUT = reply_id_r;
  // R5: Every core starts fetching at local address 0.
  assign START_PC_OUT = START_PC;

  // R13: Dormant cores receive no clock enable.
  assign CORE_CLK_EN_OUT = active_r & ~reset_r;
  assign CORE_RESET_OUT = reset_r;

  // R8: Boot parameters are driven only by the sequencer.
  generate
    for (genvar g = 0; g < NUM_CORES; g++) begin : g_boot
      assign BOOT_PARAM_OUT[g*BOOT_PARAM_W +: BOOT_PARAM_W] = boot_r[g];
    end
  endgenerate

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      state_r <= ST_IDLE;
      req_r <= '0;
      core_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (REQ_VALID_IN) begin
            req_r <= REQ_IN;
            state_r <= ST_PICK;
          end
        end
        ST_PICK: begin
          if (targeted_ok) begin
            core_r <= req_r.target[CORE_ID_W-1:0];
            state_r <= ST_COPY;
          // R2: Choose the next available core.
          end else if (free_found) begin
            core_r <= free_id;
            state_r <= ST_COPY;
          // R14: No core free, so nothing is touched.
          end else begin
            state_r <= ST_REPLY;
          end
        end
        ST_COPY: begin
          if (issued_r == LOCAL_ADDR_W'(COPY_LONGS) && !rd_pend_r) begin
            state_r <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (!buf_out_valid) begin
            state_r <= ST_INIT;
          end
        end
        ST_INIT: begin
          state_r <= ST_REPLY;
        end
        ST_REPLY: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      issued_r <= '0;
      written_r <= '0;
      rd_pend_r <= 1'b0;
    end else begin
      if (state_r == ST_PICK) begin
        issued_r <= '0;
        written_r <= '0;
      end
      // R3: Count exactly 496 reads and their answers.
      if (issue) begin
        issued_r <= issued_r + 1'b1;
        rd_pend_r <= 1'b1;
      end else if (MEM_RVALID_IN && rd_pend_r) begin
        rd_pend_r <= 1'b0;
        written_r <= written_r + 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      active_r <= '0;
      reset_r <= '0;
      for (int i = 0; i < NUM_CORES; i++) begin
        boot_r[i] <= '0;
      end
    end else begin
      // R13: A stop request makes the core dormant.
      if (STOP_VALID_IN) begin
        active_r[STOP_ID_IN] <= 1'b0;
      end
      // R12: The chosen core is stopped and held in reset while loading.
      if (state_r == ST_PICK && (targeted_ok || free_found)) begin
        active_r[targeted_ok ? req_r.target[CORE_ID_W-1:0] : free_id] <= 1'b1;
        reset_r[targeted_ok ? req_r.target[CORE_ID_W-1:0] : free_id] <= 1'b1;
      end
      // R4: Load boot parameter and release reset, which clears other specials.
      if (state_r == ST_INIT) begin
        // R6: Keep only bits 2 through 15.
        // R7: Force the two low bits to zero.
        boot_r[core_r] <= {req_r.boot_value[BOOT_PARAM_MSB:BOOT_PARAM_LSB], 2'b00};
        reset_r[core_r] <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      reply_valid_r <= 1'b0;
      reply_id_r <= '0;
    end else begin
      reply_valid_r <= (state_r == ST_PICK && !targeted_ok && !free_found) ||
                       (state_r == ST_INIT);
      // R1: Core ID on success, minus one on failure.
      if (state_r == ST_PICK && !targeted_ok && !free_found) begin
        reply_id_r <= RESULT_FAIL;
      end else if (state_r == ST_INIT) begin
        reply_id_r <= {5'h00, core_r};
      end
    end
  end
endmodule

/* File: bench/launch_checker_sva.sv */
// Checker for the launch sequencer, watching its top ports only.
// Assumes the bind below attaches it to every sequencer instance.
`timescale 1ns/1ps
module launch_checker import launch_pkg::*; (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic REQ_VALID_IN,
  input wire logic REQ_READY_OUT,
  input wire launch_req_type REQ_IN,
  input wire logic REPLY_VALID_OUT,
  input wire logic [7:0] REPLY_ID_OUT,
  input wire logic STOP_VALID_IN,
  input wire logic [CORE_ID_W-1:0] STOP_ID_IN,
  input wire logic RAM_WE_OUT,
  input wire logic RAM_READY_IN,
  input wire logic [NUM_CORES-1:0] CORE_CLK_EN_OUT,
  input wire logic [NUM_CORES*BOOT_PARAM_W-1:0] BOOT_PARAM_OUT,
  input wire logic [LOCAL_ADDR_W-1:0] START_PC_OUT
);
  logic [9:0] cnt_r;
  logic tgt_r;
  logic [3:0] id_r;
  logic [15:0] bootv_r;
  logic take;
  assign take = REQ_VALID_IN && REQ_READY_OUT;
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Counts words accepted by local RAM since the last request.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN || take) cnt_r <= '0;
    else if (RAM_WE_OUT && RAM_READY_IN) cnt_r <= cnt_r + 10'h001;
  end
  // Keeps the fields of the request being served.
  always_ff @(posedge MCLK_IN) begin
    if (take) begin
      tgt_r <= REQ_IN.targeted && !REQ_IN.target[3];
      id_r <= REQ_IN.target;
      bootv_r <= REQ_IN.boot_value[15:0];
    end
  end
  a_reply_range: assert property (
    REPLY_VALID_OUT |-> REPLY_ID_OUT < 8'h08 || REPLY_ID_OUT == RESULT_FAIL)
    else $error("reply id out of range");
  a_copy_count: assert property (
    REPLY_VALID_OUT |-> cnt_r == ((REPLY_ID_OUT == RESULT_FAIL) ? 0 : COPY_LONGS))
    else $error("wrong number of words copied");
  a_param_bits: assert property (
    REPLY_VALID_OUT && REPLY_ID_OUT != RESULT_FAIL |->
    BOOT_PARAM_OUT[{REPLY_ID_OUT[2:0], 4'h0} +: 16] == {bootv_r[15:2], 2'b00})
    else $error("boot parameter wrong");
  a_param_align: assert property (
    (BOOT_PARAM_OUT & {NUM_CORES{16'h0003}}) == '0)
    else $error("boot parameter not aligned");
  a_param_hold: assert property (
    $changed(BOOT_PARAM_OUT) |-> !REQ_READY_OUT)
    else $error("boot parameter changed outside a launch");
  a_start_pc: assert property (
    START_PC_OUT == START_PC)
    else $error("start address not zero");
  a_stop_dormant: assert property (
    STOP_VALID_IN && REQ_READY_OUT && !REQ_VALID_IN |=>
    !CORE_CLK_EN_OUT[$past(STOP_ID_IN)])
    else $error("stopped core still clocked");
  a_target_id: assert property (
    REPLY_VALID_OUT && tgt_r |-> REPLY_ID_OUT == {5'h00, id_r[2:0]})
    else $error("targeted launch started another core");
endmodule
bind core_launch_sequencer launch_checker chk_i (.*);

/* File: bench/mem_model.sv */
// Shared memory and local RAM sink beside the sequencer.
// Assumes one read outstanding; slow mode delays reads and stalls RAM.
`timescale 1ns/1ps
module mem_model import launch_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic slow_in,
  input wire logic rd_in,
  input wire logic [HUB_ADDR_W-1:0] addr_in,
  output logic rvalid_out,
  output logic [DATA_W-1:0] rdata_out,
  output logic ready_out
);
  logic [1:0] wait_r;
  logic [HUB_ADDR_W-1:0] addr_r;
  logic busy_r;
  logic tick_r;
  assign ready_out = !slow_in || tick_r;
  // Data is idle-inverted so a late sample never matches by chance.
  always_ff @(posedge clk_in) begin
    tick_r <= !tick_r && rst_n_in;
    rvalid_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (!rst_n_in) begin
      busy_r <= 1'b0;
      rdata_out <= '0;
    end else if (rd_in) begin
      busy_r <= 1'b1;
      addr_r <= addr_in;
      wait_r <= slow_in ? 2'h2 : 2'h0;
    end else if (busy_r && wait_r != 2'h0) begin
      wait_r <= wait_r - 2'h1;
    end else if (busy_r) begin
      busy_r <= 1'b0;
      rvalid_out <= 1'b1;
      rdata_out <= {~addr_r, addr_r};
    end
  end
endmodule

/* File: bench/core_launch_sequencer_tb.sv */
// Testbench for the launch sequencer, acting as the requesting core.
// Assumes mem_model answers memory reads and accepts local RAM writes.
`timescale 1ns/1ps
module core_launch_sequencer_tb import launch_pkg::*;;
  logic MCLK_IN, RST_N_IN, REQ_VALID_IN, REQ_READY_OUT, REPLY_VALID_OUT;
  logic STOP_VALID_IN, MEM_RD_OUT, MEM_RVALID_IN, RAM_WE_OUT, RAM_READY_IN;
  launch_req_type REQ_IN;
  ram_write_type RAM_WR_OUT;
  logic [7:0] REPLY_ID_OUT;
  logic [CORE_ID_W-1:0] STOP_ID_IN;
  logic [HUB_ADDR_W-1:0] MEM_ADDR_OUT, base, ha;
  logic [DATA_W-1:0] MEM_RDATA_IN;
  logic [NUM_CORES-1:0] CORE_CLK_EN_OUT, CORE_RESET_OUT;
  logic [NUM_CORES*BOOT_PARAM_W-1:0] BOOT_PARAM_OUT;
  logic [LOCAL_ADDR_W-1:0] START_PC_OUT;
  logic slow;
  logic [CORE_ID_W-1:0] want;
  int fails, checks_done, ram_cnt, cyc;
  core_launch_sequencer dut (.*);
  mem_model mem (.clk_in(MCLK_IN), .rst_n_in(RST_N_IN), .slow_in(slow),
    .rd_in(MEM_RD_OUT), .addr_in(MEM_ADDR_OUT), .rvalid_out(MEM_RVALID_IN),
    .rdata_out(MEM_RDATA_IN), .ready_out(RAM_READY_IN));
  initial begin
    MCLK_IN = 1'b0;
    forever #2 MCLK_IN = ~MCLK_IN;
  end
  task automatic stop_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge MCLK_IN) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      stop_test();
    end
  end
  always @(negedge MCLK_IN) begin
    ha = base + HUB_ADDR_W'(ram_cnt * LONG_BYTES);
    if (RAM_WE_OUT === 1'b1 && RAM_READY_IN === 1'b1) begin
      chk(RAM_WR_OUT.addr, ram_cnt);
      chk(RAM_WR_OUT.data, {~ha, ha});
      chk(RAM_WR_OUT.core, want);
      chk(CORE_RESET_OUT[want], 1'b1);
      chk(CORE_CLK_EN_OUT[want], 1'b0);
      ram_cnt++;
    end
  end
  task automatic launch(input logic t, input logic [3:0] tg, input logic [15:0] a,
    input logic [31:0] p, input logic [7:0] exp);
    int n;
    n = 0;
    ram_cnt = 0;
    base = a;
    want = exp[2:0];
    REQ_VALID_IN = 1'b1;
    REQ_IN = '{t, tg, a, p};
    while (REQ_READY_OUT !== 1'b1) @(negedge MCLK_IN);
    @(negedge MCLK_IN);
    REQ_VALID_IN = 1'b0;
    chk(REQ_READY_OUT, 1'b0);
    while (REPLY_VALID_OUT !== 1'b1 && n < 4000) begin
      @(negedge MCLK_IN);
      n++;
    end
    chk(REPLY_VALID_OUT, 1'b1);
    chk(REPLY_ID_OUT, exp);
    chk(ram_cnt, (exp == 8'hff) ? 32'h0 : 32'h1f0);
    if (exp != 8'hff) begin
      chk(BOOT_PARAM_OUT[{exp[2:0], 4'h0} +: 16], {p[15:2], 2'b00});
      chk(CORE_RESET_OUT[exp[2:0]], 1'b0);
      @(negedge MCLK_IN);
      chk(REPLY_VALID_OUT, 1'b0);
      chk(CORE_CLK_EN_OUT[exp[2:0]], 1'b1);
    end else begin
      chk(CORE_CLK_EN_OUT, 32'h000000ff);
    end
  endtask
  task automatic stop_core(input logic [2:0] id);
    STOP_VALID_IN = 1'b1;
    STOP_ID_IN = id;
    @(negedge MCLK_IN);
    STOP_VALID_IN = 1'b0;
    @(negedge MCLK_IN);
    chk(CORE_CLK_EN_OUT[id], 1'b0);
  endtask
  initial begin
    {RST_N_IN, REQ_VALID_IN, STOP_VALID_IN, STOP_ID_IN, slow} = '0;
    REQ_IN = '0;
    base = '0;
    repeat (12) @(negedge MCLK_IN);
    RST_N_IN = 1'b1;
    for (int i = 0; i < 8; i++) begin
      slow = i[0];
      // Small value shifted left by two, with stray bits to be dropped.
      launch(1'b0, 4'h0, 16'h1000 + 16'(i * 64), 32'hffff0003 | (i << 2), 8'(i));
    end
    launch(1'b0, 4'h0, 16'h2000, 32'h0, 8'hff);
    stop_core(3'h3);
    launch(1'b0, 4'h0, 16'h3000, 32'h10, 8'h03);
    launch(1'b1, 4'h5, 16'h4000, 32'h44, 8'h05);
    stop_core(3'h6);
    launch(1'b1, 4'hc, 16'h5000, 32'h8, 8'h06);
    stop_test();
  end
endmodule
